// file: logic/lpc_clk_monitor.sv
// watchdog on the external oscillator: no edge within a window means failure
`timescale 1ns/1ns
`include "lpc_cfg.svh"
module lpc_clk_monitor
(
    input  wire logic clock,
    input  wire logic sys_rst,
    lpc_mon_if.mon    mon
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       tickPrev_r;
    logic       tickPrev_nxt;
    logic       fail_r;
    logic       fail_nxt;

    always_comb
    begin
        cnt_nxt      = cnt_r;
        tickPrev_nxt = mon.extTick;
        fail_nxt     = 1'b0;
        if (!mon.enable || (mon.extTick != tickPrev_r))
            cnt_nxt = 8'h00; // R12
        else if (cnt_r == `LPC_FAIL_WINDOW)
        begin
            fail_nxt = 1'b1;
            cnt_nxt  = 8'h00;
        end
        else
            cnt_nxt = cnt_r + 8'h01;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cnt_r      <= 8'h00;
            tickPrev_r <= 1'b0;
            fail_r     <= 1'b0;
        end
        else
        begin
            cnt_r      <= cnt_nxt;
            tickPrev_r <= tickPrev_nxt;
            fail_r     <= fail_nxt;
        end
    end
    assign mon.failPulse = fail_r;

    chk_fail_needs_enable: assert property (@(posedge clock) disable iff (sys_rst) // R12
        fail_r |-> $past(mon.enable))
        else $error("failure flagged while monitor off");
endmodule : lpc_clk_monitor

// file: logic/lpc_power_ctrl.sv
// low power mode sequencer and system clock source controller
`timescale 1ns/1ns
`include "lpc_cfg.svh"
// Overview of operation
// R01 - light sleep stops only the processor clock; peripherals keep clocks
// R02 - any peripheral interrupt or event wakes from light sleep
// R03 - deep stop gates core clocks and disables pll and both oscillators
// R04 - deep stop keeps sram and registers powered and intact
// R05 - deep stop regulator mode follows the low power choice made before entry
// R06 - any enabled interrupt line wakes from deep stop
// R07 - standby switches off regulator, core domain, pll and oscillators
// R08 - standby loses sram and registers except backup and standby circuitry
// R09 - reset pin low, watchdog reset, wakeup pin rise or alarm leave standby
// R10 - real time clock and watchdog with their clocks run in every mode
// R11 - every reset selects the internal rc oscillator as clock source
// R12 - an external clock selected as source is monitored for failure
// R13 - on failure the clock returns to the internal rc oscillator
// R14 - failure raises an interrupt only when its enable is set
// R15 - software keeps main buses at most 72 mhz, slow bus at most 36 mhz
// R16 - leaving standby runs a full reset with the internal oscillator
// R17 - software selects the mode before the wait instruction starting entry
module lpc_power_ctrl
#(
    parameter int LINES = `LPC_LINE_COUNT
)
(
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [1:0]       modeSelect,
    input  wire logic             regulatorLowPower,
    input  wire logic             waitRequest,
    input  wire logic             peripheralEvent,
    input  wire logic [LINES-1:0] lineRequest,
    input  wire logic [LINES-1:0] lineEnable,
    input  wire logic             reset_pin_low_n,
    input  wire logic             independentWatchdogReset,
    input  wire logic             wakeupPin,
    input  wire logic             rtcAlarm,
    input  wire logic [1:0]       sourceSelect,
    input  wire logic             extOscTick,
    input  wire logic             failIrqEnable,
    input  wire logic             failIrqClear,
    output logic                  cpuClockEnable,
    output logic                  periphClockEnable,
    output logic                  coreDomainClockEnable,
    output logic                  pllEnable,
    output logic                  internalRcOscEnable,
    output logic                  externalOscEnable,
    output logic                  regulatorOn,
    output logic                  regulatorLowPowerOut,
    output logic                  retentionKeep,
    output logic                  backupDomainOn,
    output logic                  rtcWatchdogRun,
    output logic                  systemReset,
    output logic [1:0]            activeSource,
    output logic                  failFlag,
    output logic                  failIrq,
    output logic [2:0]            powerState
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    lpc_pkg::lpc_state_e state_r;
    lpc_pkg::lpc_state_e state_nxt;
    logic [7:0]          rstCnt_r;
    logic [7:0]          rstCnt_nxt;
    logic                wkPrev_r;
    logic                wkPrev_nxt;
    logic                lpLatch_r;
    logic                lpLatch_nxt;
    lpc_pkg::lpc_src_e   src_r;
    lpc_pkg::lpc_src_e   src_nxt;
    logic                fail_r;
    logic                fail_nxt;
    logic                stopWake;
    logic                standbyWake;
    lpc_mon_if           monLink ();

    function automatic lpc_pkg::lpc_src_e decodeSrc(input logic [1:0] sel);
        unique case (sel)
            2'h1:    decodeSrc = lpc_pkg::LPC_SRC_EXTERNAL;
            2'h2:    decodeSrc = lpc_pkg::LPC_SRC_PLL;
            default: decodeSrc = lpc_pkg::LPC_SRC_INTERNAL;
        endcase
    endfunction : decodeSrc

    assign stopWake    = |(lineRequest & lineEnable); // R06
    assign standbyWake = !reset_pin_low_n || independentWatchdogReset // R09
                      || (wakeupPin && !wkPrev_r) || rtcAlarm;

    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt   = state_r;
        rstCnt_nxt  = rstCnt_r;
        wkPrev_nxt  = wakeupPin;
        lpLatch_nxt = lpLatch_r;
        unique case (state_r)
            lpc_pkg::LPC_RUN:
                if (waitRequest) // R17
                begin
                    lpLatch_nxt = regulatorLowPower; // R05
                    if (modeSelect == `LPC_MODE_STOP)
                        state_nxt = lpc_pkg::LPC_STOP;
                    else if (modeSelect == `LPC_MODE_STANDBY)
                        state_nxt = lpc_pkg::LPC_STANDBY;
                    else
                        state_nxt = lpc_pkg::LPC_SLEEP;
                end
            lpc_pkg::LPC_SLEEP:
                if (peripheralEvent || stopWake) // R02
                    state_nxt = lpc_pkg::LPC_RUN;
            lpc_pkg::LPC_STOP:
                if (stopWake) // R06
                    state_nxt = lpc_pkg::LPC_RUN; // R04
            lpc_pkg::LPC_STANDBY:
                if (standbyWake) // R09
                begin
                    state_nxt  = lpc_pkg::LPC_WAKE_RESET; // R16
                    rstCnt_nxt = 8'h00;
                end
            lpc_pkg::LPC_WAKE_RESET:
                if (rstCnt_r == `LPC_RESET_CYCLES)
                    state_nxt = lpc_pkg::LPC_RUN;
                else
                    rstCnt_nxt = rstCnt_r + 8'h01;
            default:
                state_nxt = lpc_pkg::LPC_RUN;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_r   <= lpc_pkg::LPC_RUN;
            rstCnt_r  <= 8'h00;
            wkPrev_r  <= 1'b1;
            lpLatch_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            rstCnt_r  <= rstCnt_nxt;
            wkPrev_r  <= wkPrev_nxt;
            lpLatch_r <= lpLatch_nxt;
        end
    end

    // ----------------------------------------------------------------
    // clock source and failure handling
    // ----------------------------------------------------------------
    always_comb
    begin
        src_nxt  = src_r;
        fail_nxt = fail_r;
        if (state_r == lpc_pkg::LPC_WAKE_RESET)
            src_nxt = lpc_pkg::LPC_SRC_INTERNAL; // R16
        else if (monLink.failPulse)
            src_nxt = lpc_pkg::LPC_SRC_INTERNAL; // R13
        else if (state_r == lpc_pkg::LPC_RUN)
        begin
            src_nxt = decodeSrc(sourceSelect);
            // a failed crystal stays out until software clears the flag
            if (fail_r && src_nxt == lpc_pkg::LPC_SRC_EXTERNAL)
                src_nxt = lpc_pkg::LPC_SRC_INTERNAL; // R13
        end
        if (failIrqClear)
            fail_nxt = 1'b0;
        if (monLink.failPulse)
            fail_nxt = 1'b1; // set wins over clear
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            src_r  <= lpc_pkg::LPC_SRC_INTERNAL; // R11
            fail_r <= 1'b0;
        end
        else
        begin
            src_r  <= src_nxt;
            fail_r <= fail_nxt;
        end
    end

    // monitor is blind outside run and sleep so a stopped crystal is not a fault
    assign monLink.enable  = (src_r == lpc_pkg::LPC_SRC_EXTERNAL) // R12
                          && (state_r == lpc_pkg::LPC_RUN || state_r == lpc_pkg::LPC_SLEEP);
    assign monLink.extTick = extOscTick;

    lpc_clk_monitor u_monitor
    (
        .clock   (clock),
        .sys_rst (sys_rst),
        .mon     (monLink)
    );

    // ----------------------------------------------------------------
    // domain controls
    // ----------------------------------------------------------------
    always_comb
    begin
        cpuClockEnable        = (state_r == lpc_pkg::LPC_RUN); // R01
        periphClockEnable     = (state_r == lpc_pkg::LPC_RUN)
                             || (state_r == lpc_pkg::LPC_SLEEP); // R01
        coreDomainClockEnable = periphClockEnable; // R03
        pllEnable             = periphClockEnable && (src_r == lpc_pkg::LPC_SRC_PLL); // R03
        internalRcOscEnable   = periphClockEnable || (state_r == lpc_pkg::LPC_WAKE_RESET); // R03
        externalOscEnable     = periphClockEnable && (src_r != lpc_pkg::LPC_SRC_INTERNAL); // R07
        regulatorOn           = (state_r != lpc_pkg::LPC_STANDBY); // R07
        regulatorLowPowerOut  = (state_r == lpc_pkg::LPC_STOP) && lpLatch_r; // R05
        retentionKeep         = (state_r != lpc_pkg::LPC_STANDBY)
                             && (state_r != lpc_pkg::LPC_WAKE_RESET); // R08
        backupDomainOn        = 1'b1; // R08
        rtcWatchdogRun        = 1'b1; // R10
        systemReset           = (state_r == lpc_pkg::LPC_WAKE_RESET); // R16
    end
    assign activeSource = src_r;
    assign failFlag     = fail_r;
    assign failIrq      = fail_r && failIrqEnable; // R14
    assign powerState   = state_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_sleep_periph_on: assert property (@(posedge clock) disable iff (sys_rst) // R01
        state_r == lpc_pkg::LPC_SLEEP |-> !cpuClockEnable && periphClockEnable)
        else $error("sleep clocks wrong");
    chk_sleep_wake_event: assert property (@(posedge clock) disable iff (sys_rst) // R02
        state_r == lpc_pkg::LPC_SLEEP && peripheralEvent |=> state_r == lpc_pkg::LPC_RUN)
        else $error("sleep did not wake");
    chk_stop_clocks_off: assert property (@(posedge clock) disable iff (sys_rst) // R03
        state_r == lpc_pkg::LPC_STOP |-> !pllEnable && !internalRcOscEnable
            && !externalOscEnable && !coreDomainClockEnable && retentionKeep)
        else $error("stop clocks running");
    chk_stop_reg_mode: assert property (@(posedge clock) disable iff (sys_rst) // R05
        state_r == lpc_pkg::LPC_RUN && waitRequest && modeSelect == `LPC_MODE_STOP
        |=> regulatorLowPowerOut == $past(regulatorLowPower))
        else $error("regulator mode not latched");
    chk_stop_line_wake: assert property (@(posedge clock) disable iff (sys_rst) // R06
        state_r == lpc_pkg::LPC_STOP && stopWake |=> state_r == lpc_pkg::LPC_RUN)
        else $error("stop did not wake");
    chk_standby_power_off: assert property (@(posedge clock) disable iff (sys_rst) // R07
        state_r == lpc_pkg::LPC_STANDBY |-> !regulatorOn && !retentionKeep && rtcWatchdogRun)
        else $error("standby power wrong");
    chk_standby_exit_reset: assert property (@(posedge clock) disable iff (sys_rst) // R16
        state_r == lpc_pkg::LPC_STANDBY && standbyWake
        |=> systemReset [*8] ##1 systemReset ##1 !systemReset && activeSource == 2'h0)
        else $error("standby exit reset wrong");
    chk_fail_fallback: assert property (@(posedge clock) disable iff (sys_rst) // R13
        monLink.failPulse |=> activeSource == 2'h0 && failFlag)
        else $error("no fallback after failure");
    chk_fail_holds_internal: assert property (@(posedge clock) disable iff (sys_rst) // R13
        failFlag |-> activeSource != 2'h1)
        else $error("failed crystal selected again");
    chk_fail_set_wins: assert property (@(posedge clock) disable iff (sys_rst) // R14
        monLink.failPulse && failIrqClear |=> failFlag)
        else $error("clear beat a new failure");
    chk_irq_gated: assert property (@(posedge clock) disable iff (sys_rst) // R14
        failIrq |-> failFlag && failIrqEnable)
        else $error("irq without enable");
    cov_sleep: cover property (@(posedge clock) state_r == lpc_pkg::LPC_SLEEP ##1
        state_r == lpc_pkg::LPC_RUN);
    cov_stop: cover property (@(posedge clock) state_r == lpc_pkg::LPC_STOP ##1
        state_r == lpc_pkg::LPC_RUN);
    cov_standby: cover property (@(posedge clock) state_r == lpc_pkg::LPC_WAKE_RESET);
    cov_fail: cover property (@(posedge clock) monLink.failPulse);
endmodule : lpc_power_ctrl

// file: pkg/lpc_cfg.svh
// timing and encoding constants for the low power and clock controller
`ifndef LPC_CFG_SVH
`define LPC_CFG_SVH
`define LPC_CLK_HZ        20000000
`define LPC_MODE_SLEEP    2'h0
`define LPC_MODE_STOP     2'h1
`define LPC_MODE_STANDBY  2'h2
`define LPC_LINE_COUNT    23
`define LPC_FAIL_WINDOW   8'h10
`define LPC_RESET_CYCLES  8'h08
`endif

// file: pkg/lpc_mon_if.sv
// link between the controller and its external clock monitor
`timescale 1ns/1ns
interface lpc_mon_if;
    logic enable;
    logic extTick;
    logic failPulse;
    modport ctrl (output enable, output extTick, input failPulse);
    modport mon  (input enable, input extTick, output failPulse);
endinterface : lpc_mon_if

// file: pkg/lpc_pkg.sv
// types shared by the low power and clock controller
package lpc_pkg;
    typedef enum logic [1:0] {
        LPC_SRC_INTERNAL,
        LPC_SRC_EXTERNAL,
        LPC_SRC_PLL
    } lpc_src_e;
    typedef enum logic [2:0] {
        LPC_RUN,
        LPC_SLEEP,
        LPC_STOP,
        LPC_STANDBY,
        LPC_WAKE_RESET
    } lpc_state_e;
endpackage : lpc_pkg

// file: testbench/low_power_mode_and_clock_control_tb.sv
// self-checking bench for the low power mode and clock controller
`timescale 1ns/1ns
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
            failCount++; \
        end \
    end
module low_power_mode_and_clock_control_tb;
    typedef struct packed {
        logic [1:0]  mode;
        logic        lp;
        logic [2:0]  kind;
        logic [2:0]  state;
        logic [10:0] exp;
        logic [10:0] mask;
    } lpc_row_s;
    // enables: cpu periph core pll rc ext regOn regLp retain backup rtc
    lpc_row_s rows [8] = '{
        '{2'h0, 1'h0, 3'h0, 3'h1, 11'h313, 11'h713}, '{2'h3, 1'h0, 3'h1, 3'h1, 11'h313, 11'h713},
        '{2'h1, 1'h0, 3'h1, 3'h2, 11'h017, 11'h5ff}, '{2'h1, 1'h1, 3'h1, 3'h2, 11'h01f, 11'h5ff},
        '{2'h2, 1'h0, 3'h2, 3'h3, 11'h003, 11'h4f7}, '{2'h2, 1'h0, 3'h3, 3'h3, 11'h003, 11'h4f7},
        '{2'h2, 1'h0, 3'h4, 3'h3, 11'h003, 11'h4f7}, '{2'h2, 1'h0, 3'h5, 3'h3, 11'h003, 11'h4f7}};
    logic        clock = 1'b0, sys_rst = 1'b1, regulatorLowPower = 1'b0, waitRequest = 1'b0;
    logic        failIrqEnable = 1'b0, failIrqClear = 1'b0, oscFreeze = 1'b0, fire = 1'b0;
    logic [1:0]  modeSelect = 2'h0, sourceSelect = 2'h0;
    logic [2:0]  kind = 3'h0;
    logic [4:0]  lineSel = 5'h16;
    logic [22:0] lineEnable = 23'h400000;
    logic [22:0] lineRequest;
    logic        peripheralEvent, reset_pin_low_n, independentWatchdogReset, wakeupPin, rtcAlarm;
    logic        extOscTick, cpuClockEnable, periphClockEnable, coreDomainClockEnable, pllEnable;
    logic        internalRcOscEnable, externalOscEnable, regulatorOn, regulatorLowPowerOut;
    logic        retentionKeep, backupDomainOn, rtcWatchdogRun, systemReset, failFlag, failIrq;
    logic [1:0]  activeSource;
    logic [2:0]  powerState;
    logic [7:0]  n;
    logic [10:0] seen;
    int          failCount = 0, comparisons = 0;
    assign seen = {cpuClockEnable, periphClockEnable, coreDomainClockEnable, pllEnable,
                   internalRcOscEnable, externalOscEnable, regulatorOn, regulatorLowPowerOut,
                   retentionKeep, backupDomainOn, rtcWatchdogRun};
    always #25 clock = ~clock;
    lpc_power_ctrl #(.LINES(23)) DUT (.clock(clock), .sys_rst(sys_rst),
        .modeSelect(modeSelect), .regulatorLowPower(regulatorLowPower),
        .waitRequest(waitRequest), .peripheralEvent(peripheralEvent),
        .lineRequest(lineRequest), .lineEnable(lineEnable), .reset_pin_low_n(reset_pin_low_n),
        .independentWatchdogReset(independentWatchdogReset), .wakeupPin(wakeupPin),
        .rtcAlarm(rtcAlarm), .sourceSelect(sourceSelect), .extOscTick(extOscTick),
        .failIrqEnable(failIrqEnable), .failIrqClear(failIrqClear),
        .cpuClockEnable(cpuClockEnable), .periphClockEnable(periphClockEnable),
        .coreDomainClockEnable(coreDomainClockEnable), .pllEnable(pllEnable),
        .internalRcOscEnable(internalRcOscEnable), .externalOscEnable(externalOscEnable),
        .regulatorOn(regulatorOn), .regulatorLowPowerOut(regulatorLowPowerOut),
        .retentionKeep(retentionKeep), .backupDomainOn(backupDomainOn),
        .rtcWatchdogRun(rtcWatchdogRun), .systemReset(systemReset),
        .activeSource(activeSource), .failFlag(failFlag), .failIrq(failIrq),
        .powerState(powerState));
    lpc_far_model #(.LINES(23)) farEnd (.clock(clock), .oscOn(externalOscEnable),
        .oscFreeze(oscFreeze), .fire(fire), .kind(kind), .lineSel(lineSel),
        .extOscTick(extOscTick), .peripheralEvent(peripheralEvent), .lineRequest(lineRequest),
        .reset_pin_low_n(reset_pin_low_n), .independentWatchdogReset(independentWatchdogReset),
        .wakeupPin(wakeupPin), .rtcAlarm(rtcAlarm));
    // ------------------------------------------------------------
    // bus-free helpers: inputs always move 1 ns after the edge
    // ------------------------------------------------------------
    task automatic step(input int cycles);
        repeat (cycles) @(posedge clock);
        #1;
    endtask : step
    task automatic enter(input logic [1:0] mode, input logic lp);
        modeSelect = mode;
        regulatorLowPower = lp;
        step(1);
        waitRequest = 1'b1;
        step(1);
        waitRequest = 1'b0;
    endtask : enter
    task automatic wake(input logic [2:0] k);
        kind = k;
        fire = 1'b1;
        step(1);
        fire = 1'b0;
    endtask : wake
    task automatic completeRun;
        if (failCount == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : completeRun
    initial
    begin
        step(3000);
        failCount++;
        completeRun();
    end
    // ------------------------------------------------------------
    // table of entries and wakeups, then the awkward cases
    // ------------------------------------------------------------
    initial
    begin
        step(2);
        sys_rst = 1'b0;
        `CHK("powerState", 3'h0, powerState)
        `CHK("activeSource", 2'h0, activeSource)
        `CHK("failFlag", 1'b0, failFlag)
        for (int i = 0; i < 8; i++)
        begin
            enter(rows[i].mode, rows[i].lp);
            `CHK("powerState", rows[i].state, powerState)
            `CHK("enables", rows[i].exp, seen & rows[i].mask)
            wake(rows[i].kind);
            if (rows[i].state == 3'h3)
            begin
                `CHK("powerState", 3'h4, powerState)
                n = 8'h00;
                while (systemReset === 1'b1 && n < 8'h14)
                begin
                    `CHK("activeSource", 2'h0, activeSource)
                    n++;
                    step(1);
                end
                `CHK("resetLength", 8'h09, n)
            end
            `CHK("powerState", 3'h0, powerState)
            step(1);
        end
        enter(2'h1, 1'b0);
        lineSel = 5'h03;
        wake(3'h1);
        `CHK("powerState", 3'h2, powerState)
        sourceSelect = 2'h1;
        modeSelect = 2'h2;
        waitRequest = 1'b1;
        step(2);
        waitRequest = 1'b0;
        sourceSelect = 2'h0;
        `CHK("powerState", 3'h2, powerState)
        `CHK("activeSource", 2'h0, activeSource)
        lineEnable = 23'h000008;
        wake(3'h1);
        `CHK("powerState", 3'h0, powerState)
        // clock failure with the interrupt enabled, then masked
        sourceSelect = 2'h1;
        failIrqEnable = 1'b1;
        step(4);
        `CHK("activeSource", 2'h1, activeSource)
        `CHK("externalOscEnable", 1'b1, externalOscEnable)
        // clear held high across the failure: the new failure must still win
        failIrqClear = 1'b1;
        oscFreeze = 1'b1;
        n = 8'h00;
        while (activeSource !== 2'h0 && n < 8'h28)
        begin
            n++;
            step(1);
        end
        failIrqClear = 1'b0;
        `CHK("activeSource", 2'h0, activeSource)
        `CHK("failIrq", 1'b1, failIrq)
        step(1);
        `CHK("activeSource", 2'h0, activeSource)
        sourceSelect = 2'h0;
        failIrqEnable = 1'b0;
        oscFreeze = 1'b0;
        step(1);
        `CHK("failFlag", 1'b1, failFlag)
        `CHK("failIrq", 1'b0, failIrq)
        failIrqClear = 1'b1;
        step(1);
        failIrqClear = 1'b0;
        step(1);
        `CHK("failFlag", 1'b0, failFlag)
        // a reset in mid-run drops the external source
        sourceSelect = 2'h1;
        step(4);
        sys_rst = 1'b1;
        step(1);
        `CHK("activeSource", 2'h0, activeSource)
        sys_rst = 1'b0;
        step(1);
        // pll source runs in run and is stopped by deep stop
        sourceSelect = 2'h2;
        step(2);
        `CHK("activeSource", 2'h2, activeSource)
        `CHK("pllEnable", 1'b1, pllEnable)
        enter(2'h1, 1'b0);
        `CHK("pllEnable", 1'b0, pllEnable)
        wake(3'h1);
        `CHK("powerState", 3'h0, powerState)
        completeRun();
    end
endmodule : low_power_mode_and_clock_control_tb

// file: testbench/lpc_far_model.sv
// far side model: external crystal and the wakeup event sources
`timescale 1ns/1ns
module lpc_far_model
#(
    parameter int LINES = 23
)
(
    input  wire logic             clock,
    input  wire logic             oscOn,
    input  wire logic             oscFreeze,
    input  wire logic             fire,
    input  wire logic [2:0]       kind,
    input  wire logic [4:0]       lineSel,
    output logic                  extOscTick,
    output logic                  peripheralEvent,
    output logic [LINES-1:0]      lineRequest,
    output logic                  reset_pin_low_n,
    output logic                  independentWatchdogReset,
    output logic                  wakeupPin,
    output logic                  rtcAlarm
);
    // a dead or disabled crystal holds its level, it never keeps swinging
    initial extOscTick = 1'b0;
    always @(posedge clock)
        if (oscOn && !oscFreeze)
            extOscTick <= ~extOscTick;
    // one event of the chosen kind while fire is high
    assign peripheralEvent          = fire && (kind == 3'h0);
    assign lineRequest              = (fire && (kind == 3'h1)) ? (LINES'(1) << lineSel) : '0;
    assign reset_pin_low_n          = !(fire && (kind == 3'h2));
    assign independentWatchdogReset = fire && (kind == 3'h3);
    assign wakeupPin                = fire && (kind == 3'h4);
    assign rtcAlarm                 = fire && (kind == 3'h5);
endmodule : lpc_far_model
